// File: hw/bist_mask_defines.svh
// offsets, field positions, reset values for the self-test fault mask bank
`ifndef BIST_MASK_DEFINES_SVH
`define BIST_MASK_DEFINES_SVH

// register indices; the byte address is four times the index
`define VOLT_MASK_IDX   10'h019
`define TEMP_MASK_IDX   10'h01a
`define SPARE1_IDX      10'h01b
`define IRQ_STAT_IDX    10'h020
`define IRQ_MASK_IDX    10'h021
`define LIVE_FLT_IDX    10'h022

// field positions
`define OV_BIT          1
`define UV_BIT          0
`define UT_BIT          1
`define OT_BIT          0
`define AUX_LSB         2
`define AUX_MSB         7
`define VOLT_W          2
`define TEMP_W          8
`define STAT_W          10

// reset values
`define MASK_RST        8'h00
`define SPARE_RST       8'h00
`define STAT_RST        10'h000

`endif

// File: hw/bist_mask_pkg.sv
// types shared by the self-test fault mask bank
package bist_mask_pkg;

    typedef struct packed {
        logic ov;
        logic uv;
    } volt_faults_s;

    typedef struct packed {
        logic [5:0] aux;
        logic       ut;
        logic       ot;
    } temp_faults_s;

    typedef enum logic [2:0] {
        SEL_NONE  = 3'h0,
        SEL_VOLT  = 3'h1,
        SEL_TEMP  = 3'h3,
        SEL_SPARE = 3'h2,
        SEL_STAT  = 3'h6,
        SEL_IRQM  = 3'h7,
        SEL_LIVE  = 3'h5
    } reg_sel_e;

endpackage : bist_mask_pkg

// File: hw/mask_gate.sv
// synchroniser, mask gate and rising-edge event for a group of fault lines
`timescale 1ns/1ps
module mask_gate #(
    parameter int W = 2
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] raw,
    input  wire logic [W-1:0] mask,
    output logic      [W-1:0] live,
    output logic      [W-1:0] signalled,
    output logic      [W-1:0] event_p
);
    logic [W-1:0] sync1_q;
    logic [W-1:0] sync2_q;
    logic [W-1:0] sig_d;
    logic [W-1:0] sig_q;
    logic [W-1:0] evt_q;

    // comparator outputs are asynchronous to pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
        end
    end

    assign sig_d = sync2_q & ~mask;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sig_q <= '0;
            evt_q <= '0;
        end else begin
            sig_q <= sig_d;
            evt_q <= sig_d & ~sig_q;
        end
    end

    assign live      = sync2_q;
    assign signalled = sig_q;
    assign event_p   = evt_q;

endmodule : mask_gate

// File: hw/bist_fault_mask_regs.sv
// apb register bank masking comparator and aux channel self-test faults
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "bist_mask_defines.svh"
module bist_fault_mask_regs
    import bist_mask_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    input  wire logic [3:0]   pstrb,
    output logic              pready,
    output logic      [31:0]  prdata,
    output logic              pslverr,
    input  wire volt_faults_s volt_comp_test_faults,
    input  wire temp_faults_s temp_comp_test_faults,
    output volt_faults_s      volt_faults_signalled,
    output temp_faults_s      temp_faults_signalled,
    output logic      [7:0]   cell_input_one_corr,
    output logic              irq
);
    logic [7:0]         volt_mask_q;
    logic [7:0]         temp_mask_q;
    logic [7:0]         spare_q;
    logic [`STAT_W-1:0] stat_q;
    logic [`STAT_W-1:0] irqm_q;
    logic [31:0]        prdata_q;
    logic               pslverr_q;
    reg_sel_e           sel;
    logic               setup_ph;
    logic               access_ph;
    logic               wr_ok;
    logic [`STAT_W-1:0] evt;
    logic [`STAT_W-1:0] w1c;
    logic [`VOLT_W-1:0] volt_live;
    logic [`VOLT_W-1:0] volt_sig;
    logic [`VOLT_W-1:0] volt_evt;
    logic [`TEMP_W-1:0] temp_live;
    logic [`TEMP_W-1:0] temp_sig;
    logic [`TEMP_W-1:0] temp_evt;
    logic [31:0]        rd_d;

    // address decode; misaligned or unmapped words select nothing
    always_comb begin
        sel = SEL_NONE;
        if (paddr[1:0] == 2'h0) begin
            unique case (paddr[11:2])
                `VOLT_MASK_IDX: sel = SEL_VOLT;
                `TEMP_MASK_IDX: sel = SEL_TEMP;
                `SPARE1_IDX:    sel = SEL_SPARE;
                `IRQ_STAT_IDX:  sel = SEL_STAT;
                `IRQ_MASK_IDX:  sel = SEL_IRQM;
                `LIVE_FLT_IDX:  sel = SEL_LIVE;
                default:        sel = SEL_NONE;
            endcase
        end
    end

    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;
    assign wr_ok     = access_ph && pwrite && (sel != SEL_NONE);

    // the live fault word is read-only; writes there are dropped quietly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            volt_mask_q <= `MASK_RST;
        end else if (wr_ok && sel == SEL_VOLT && pstrb[0]) begin
            volt_mask_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_mask_q <= `MASK_RST;
        end else if (wr_ok && sel == SEL_TEMP && pstrb[0]) begin
            temp_mask_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spare_q <= `SPARE_RST;
        end else if (wr_ok && sel == SEL_SPARE && pstrb[0]) begin
            spare_q <= pwdata[7:0];
        end
    end

    assign cell_input_one_corr = spare_q;

    // fault gating; masks apply to the synchronised comparator lines
    mask_gate #(
        .W (`VOLT_W)
    ) u_volt_gate (
        .pclk      (pclk),
        .presetn   (presetn),
        .raw       (volt_comp_test_faults),
        .mask      ({volt_mask_q[`OV_BIT], volt_mask_q[`UV_BIT]}),
        .live      (volt_live),
        .signalled (volt_sig),
        .event_p   (volt_evt)
    );

    mask_gate #(
        .W (`TEMP_W)
    ) u_temp_gate (
        .pclk      (pclk),
        .presetn   (presetn),
        .raw       (temp_comp_test_faults),
        .mask      (temp_mask_q),
        .live      (temp_live),
        .signalled (temp_sig),
        .event_p   (temp_evt)
    );

    assign volt_faults_signalled = volt_faults_s'(volt_sig);
    assign temp_faults_signalled = temp_faults_s'(temp_sig);

    // interrupt status and mask share one layout: temp in 9:2, volt in 1:0
    assign evt = {temp_evt, volt_evt};
    assign w1c = (wr_ok && sel == SEL_STAT) ?
                 {pwdata[9:8] & {2{pstrb[1]}}, pwdata[7:0] & {8{pstrb[0]}}} :
                 `STAT_RST;

    // a new event in the clearing cycle survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= `STAT_RST;
        end else begin
            stat_q <= (stat_q & ~w1c) | evt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irqm_q <= `STAT_RST;
        end else if (wr_ok && sel == SEL_IRQM) begin
            if (pstrb[0]) begin
                irqm_q[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                irqm_q[9:8] <= pwdata[9:8];
            end
        end
    end

    assign irq = |(stat_q & irqm_q);

    // read data is caught in the setup cycle so prdata comes from flops;
    // status set during the access cycle shows on the next read
    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (sel)
            SEL_VOLT:  rd_d[7:0] = volt_mask_q;
            SEL_TEMP:  rd_d[7:0] = temp_mask_q;
            SEL_SPARE: rd_d[7:0] = spare_q;
            SEL_STAT:  rd_d[9:0] = stat_q;
            SEL_IRQM:  rd_d[9:0] = irqm_q;
            SEL_LIVE:  rd_d[9:0] = {temp_live, volt_live};
            SEL_NONE:  rd_d      = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup_ph) begin
            prdata_q  <= pwrite ? 32'h0000_0000 : rd_d;
            pslverr_q <= (sel == SEL_NONE);
        end
    end

    // zero wait states: every access phase completes at once
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = access_ph && pslverr_q;

    // ---- checks ----
    property ov_blocked_p;
        @(posedge pclk) disable iff (!presetn)
        volt_sig[1] |-> $past(!volt_mask_q[`OV_BIT]);
    endproperty
    ov_mask_gate_a: assert property (ov_blocked_p)
        else $error("overvoltage fault signalled while masked");

    uv_mask_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        volt_mask_q[`UV_BIT] && $past(volt_mask_q[`UV_BIT]) |-> !volt_sig[0])
        else $error("undervoltage fault signalled while masked");

    ut_mask_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        temp_faults_signalled.ut |-> $past(!temp_mask_q[`UT_BIT]))
        else $error("undertemperature fault signalled while masked");

    temp_layout_map_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_ok && sel == SEL_TEMP && pstrb[0] |=>
        temp_mask_q[`AUX_MSB:`AUX_LSB] == $past(pwdata[7:2]) &&
        temp_mask_q[`UT_BIT] == $past(pwdata[1]) &&
        temp_mask_q[`OT_BIT] == $past(pwdata[0]))
        else $error("temperature mask field layout wrong");

    aux_chan_mask_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (temp_faults_signalled.aux & $past(temp_mask_q[`AUX_MSB:`AUX_LSB])) == 6'h00)
        else $error("masked aux channel fault signalled");

    aux_chan_pass_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        temp_live[`AUX_LSB] && !temp_mask_q[`AUX_LSB] ##1
        $stable(temp_mask_q[`AUX_LSB]) |-> temp_faults_signalled.aux[0])
        else $error("unmasked aux channel fault not signalled");

    spare_readback_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_ok && sel == SEL_SPARE && pstrb[0] |=>
        cell_input_one_corr == $past(pwdata[7:0]))
        else $error("spare register did not store written byte");

    reset_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !$past(presetn) |-> volt_mask_q == 8'h00 && temp_mask_q == 8'h00 &&
        spare_q == 8'h00)
        else $error("mask or spare not zero after reset");

    volt_upper_keep_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_ok && sel == SEL_VOLT && pstrb[0] |=>
        volt_mask_q[7:2] == $past(pwdata[7:2]))
        else $error("voltage mask upper bits not stored");

    stat_set_wins_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        evt[1] && w1c[1] |=> stat_q[1])
        else $error("event lost against clear");

    irq_follow_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        stat_q[0] && irqm_q[0] |-> irq)
        else $error("unmasked status bit left irq low");

    unmapped_err_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup_ph && sel == SEL_NONE ##1 access_ph |-> pslverr)
        else $error("unmapped access not flagged");

    read_value_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup_ph && !pwrite && sel == SEL_TEMP ##1 access_ph |->
        prdata[7:0] == $past(temp_mask_q) && prdata[31:8] == 24'h000000)
        else $error("temperature mask read back wrong");

    ot_mask_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        temp_faults_signalled.ot |-> $past(!temp_mask_q[`OT_BIT]))
        else $error("overtemperature fault signalled while masked");

    ov_fault_pass_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        volt_live[1] && !volt_mask_q[`OV_BIT] |=> volt_sig[1])
        else $error("unmasked overvoltage fault not signalled");

    stat_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        w1c[0] && !evt[0] |=> !stat_q[0])
        else $error("written one did not clear status bit");

    // a refused write must leave the mask and spare bytes alone
    bad_write_drop_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        access_ph && pwrite && sel == SEL_NONE |=>
        $stable(volt_mask_q) && $stable(temp_mask_q) && $stable(spare_q))
        else $error("refused write changed a register");

    wr_temp_c: cover property (
        @(posedge pclk) disable iff (!presetn)
        wr_ok && sel == SEL_TEMP);

    masked_fault_c: cover property (
        @(posedge pclk) disable iff (!presetn)
        volt_live[1] && volt_mask_q[`OV_BIT]);

    irq_rise_c: cover property (
        @(posedge pclk) disable iff (!presetn)
        $rose(irq));

    spare_read_c: cover property (
        @(posedge pclk) disable iff (!presetn)
        access_ph && !pwrite && sel == SEL_SPARE);

    set_clear_clash_c: cover property (
        @(posedge pclk) disable iff (!presetn)
        evt[1] && w1c[1]);

endmodule : bist_fault_mask_regs

// File: verif/bist_fault_mask_regs_tb.sv
// self-checking bench for the self-test fault mask register bank
`timescale 1ns/1ps
module bist_fault_mask_regs_tb
    import bist_mask_pkg::*;
();
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd, r;
    logic [3:0]   pstrb;
    volt_faults_s vf, vs;
    temp_faults_s tf, ts;
    logic [7:0]   corr;
    integer       seed, num_errors, num_checks, i;

    bist_fault_mask_regs i_bist_fault_mask_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .volt_comp_test_faults(vf), .temp_comp_test_faults(tf),
        .volt_faults_signalled(vs), .temp_faults_signalled(ts),
        .cell_input_one_corr(corr), .irq(irq)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    function automatic logic [7:0] gate(input logic [7:0] raw, input logic [7:0] m);
        return raw & ~m;
    endfunction : gate

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // entered just after a rising edge; holds the request until pready is seen high or 16 access edges pass
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        logic rdy;
        int   n;
        rdy = 1'b0;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        while (rdy !== 1'b1 && n < 16) begin
            @(posedge pclk);
            rdy = pready;
            q   = prdata;
            e   = pslverr;
            n++;
        end
        if (rdy !== 1'b1) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED pready expected 1 seen %b", rdy);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        // idle edge so the next request never lands in the same time step
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, err);
    endtask : wr

    task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd, err);
        check(name, rd, exp);
    endtask : rdchk

    initial begin
        #2_000_000;
        num_errors = num_errors + 1;
        $display("CHECK FAILED watchdog expected done seen hang");
        finish_test();
    end

    initial begin
        seed = 32'h424e;
        num_errors = 0;
        num_checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        vf = '0;
        tf = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);

        rdchk("volt mask rst", 12'h064, 32'h0);
        rdchk("temp mask rst", 12'h068, 32'h0);
        rdchk("spare rst", 12'h06c, 32'h0);
        check("corr rst", {24'h0, corr}, 32'h0);
        $display("test reset values done");

        for (i = 0; i < 8; i++) begin
            r = $random(seed);
            if (i == 0) r = 32'hffffffff;
            wr(12'h064, {24'h0, r[7:0]});
            wr(12'h068, {24'h0, r[15:8]});
            wr(12'h06c, {24'h0, r[23:16]});
            rdchk("volt mask", 12'h064, {24'h0, r[7:0]});
            rdchk("temp mask", 12'h068, {24'h0, r[15:8]});
            rdchk("spare", 12'h06c, {24'h0, r[23:16]});
            check("corr", {24'h0, corr}, {24'h0, r[23:16]});
        end
        $display("test readback done");

        // byte 0 masks, byte 1 temp masks, bits 17:16 volt raw, byte 3 temp raw
        for (i = 0; i < 24; i++) begin
            r = $random(seed);
            if (i == 0) r = 32'hff03_0000;
            if (i == 1) r = 32'hff03_ff03;
            wr(12'h064, {24'h0, r[7:0]});
            wr(12'h068, {24'h0, r[15:8]});
            vf <= r[17:16];
            tf <= r[31:24];
            repeat (5) @(posedge pclk);
            check("volt sig", {30'h0, vs}, {24'h0, gate({6'h0, r[17:16]}, r[7:0])});
            check("temp sig", {24'h0, ts}, {24'h0, gate(r[31:24], r[15:8])});
            rdchk("live", 12'h088, {22'h0, r[31:24], r[17:16]});
        end
        $display("test masking done");

        vf <= '0;
        tf <= '0;
        wr(12'h064, 32'h0);
        wr(12'h068, 32'h0);
        wr(12'h084, 32'h3ff);
        repeat (5) @(posedge pclk);
        wr(12'h080, 32'h3ff);
        check("irq idle", {31'h0, irq}, 32'h0);
        vf <= 2'b10;
        repeat (6) @(posedge pclk);
        rdchk("stat ov", 12'h080, 32'h2);
        check("irq set", {31'h0, irq}, 32'h1);
        wr(12'h084, 32'h0);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(12'h084, 32'h3ff);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        wr(12'h080, 32'h2);
        check("irq cleared", {31'h0, irq}, 32'h0);
        rdchk("stat clr", 12'h080, 32'h0);
        wr(12'h064, 32'h1);
        vf <= 2'b11;
        repeat (6) @(posedge pclk);
        rdchk("stat uv masked", 12'h080, 32'h0);
        vf <= 2'b00;
        wr(12'h080, 32'h3ff);
        vf <= 2'b10;
        repeat (2) @(posedge pclk);
        wr(12'h080, 32'h2);
        rdchk("stat set wins", 12'h080, 32'h2);
        $display("test interrupt done");

        apb(1'b0, 12'h090, 32'h0, rd, err);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        apb(1'b1, 12'h065, 32'hff, rd, err);
        check("misaligned err", {31'h0, err}, 32'h1);
        pstrb <= 4'he;
        wr(12'h064, 32'hff);
        pstrb <= 4'hf;
        rdchk("volt kept", 12'h064, 32'h1);
        $display("test refused access done");
        finish_test();
    end
endmodule : bist_fault_mask_regs_tb
